/* pivm_cpu_model.sv */
/*
  CPU-side model: after a set latency it clears the flags of the served vector.
  Assumes the map's registered request and a latency from the bench.
*/
`timescale 1ns/1ps
module pivm_cpu_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire pivm_pkg::pivm_cpu_req_type cpu_request,
  input wire logic [3:0] lat,
  output pivm_pkg::pivm_event_type clr
);
  import pivm_pkg::*;
  function automatic logic [4:0] vec_of(int b);
    return b < 17 ? 5'(25 - b) : b < 19 ? 5'h08 : b < 21 ? 5'(26 - b) : 5'(24 - b);
  endfunction : vec_of
  // One process owns the clear lines, so they idle low from time zero.
  always
  begin
    clr = '0;
    @(posedge clk);
    if (reset_n && cpu_request.valid)
    begin
      repeat (lat) @(posedge clk);
      #1;
      for (int b = 0; b < 24; b++)
        clr[b] = vec_of(b) == cpu_request.vector;
      @(posedge clk);
      #1 clr = '0;
      // The request register lags the clear by two edges, so wait them out.
      repeat (2) @(posedge clk);
    end
  end
endmodule : pivm_cpu_model

/* pivm_pkg.sv */
/*
  Shared constants and types for the peripheral interrupt vector map.
  Assumes one device clock and a synchronous active-low reset.
*/
package pivm_pkg;
  localparam int NUM_VECTORS = 26;
  localparam int VEC_WIDTH = 5;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_NMI = 5'h01;
  localparam logic [4:0] VEC_VLM = 5'h02;
  localparam logic [4:0] VEC_PORT = 5'h03;
  localparam logic [4:0] VEC_RTC_COUNT_IRQ = 5'h06;
  localparam logic [4:0] VEC_PERIODIC_TIMER_IRQ = 5'h07;
  localparam logic [4:0] VEC_TA_OVF = 5'h08;
  localparam logic [4:0] VEC_TA_HUNF = 5'h09;
  localparam logic [4:0] VEC_TA_CMP0 = 5'h0a;
  localparam logic [4:0] VEC_TA_CMP1 = 5'h0b;
  localparam logic [4:0] VEC_TA_CMP2 = 5'h0c;
  localparam logic [4:0] VEC_TB = 5'h0d;
  localparam logic [4:0] VEC_TD_OVF = 5'h0e;
  localparam logic [4:0] VEC_TD_TRIG = 5'h0f;
  localparam logic [4:0] VEC_AC = 5'h10;
  localparam logic [4:0] VEC_ADC_RES = 5'h11;
  localparam logic [4:0] VEC_ADC_WIN = 5'h12;
  localparam logic [4:0] VEC_TWI_T = 5'h13;
  localparam logic [4:0] VEC_TWI_C = 5'h14;
  localparam logic [4:0] VEC_SPI = 5'h15;
  localparam logic [4:0] VEC_RXC = 5'h16;
  localparam logic [4:0] VEC_DRE = 5'h17;
  localparam logic [4:0] VEC_TXC = 5'h18;
  localparam logic [4:0] VEC_NVM = 5'h19;
  localparam logic [25:0] FLAGS_RESET = 26'h0000000;
  localparam logic [25:0] ENABLE_RESET = 26'h0000000;

  // Per-source events, software writes and the per-source view.
  typedef struct packed {
    logic checksum_scan_nmi;
    logic voltage_level_monitor_irq;
    logic port_pin_change_irq;
    logic rtc_count_irq;
    logic periodic_timer_irq;
    logic timer_a_overflow_irq;
    logic timer_a_low_underflow_irq;
    logic timer_a_high_underflow_irq;
    logic timer_a_compare0_irq;
    logic timer_a_compare1_irq;
    logic timer_a_compare2_irq;
    logic timer_b_irq;
    logic timer_d_overflow_irq;
    logic timer_d_trigger_irq;
    logic comparator_irq;
    logic converter_result_ready_irq;
    logic converter_window_irq;
    logic two_wire_target_irq;
    logic two_wire_controller_irq;
    logic spi_irq;
    logic serial_rx_complete_irq;
    logic serial_data_empty_irq;
    logic serial_tx_complete_irq;
    logic nvm_ready_irq;
  } pivm_event_type;

  typedef struct packed {
    logic valid;
    logic nmi;
    logic [4:0] vector;
  } pivm_cpu_req_type;
endpackage : pivm_pkg

/* pivm_prio_enc.sv */
/*
  Lowest-index-first priority encoder over the vector request lines.
  Assumes a combinational caller that registers the result.
*/
`timescale 1ns/1ps
module pivm_prio_enc #(
  parameter int WIDTH = 26,
  parameter int IDX_W = 5
) (
  input wire logic [WIDTH-1:0] req,
  output logic any,
  output logic [IDX_W-1:0] index
);
  always_comb
  begin
    any = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        index = IDX_W'(i);
      end
    end
  end
endmodule : pivm_prio_enc

/* pivm_vector_map.sv */
/*
  Peripheral interrupt vector map: per-source flags and enables, request
  generation, global gating and lowest-vector selection for the CPU.
  Assumes all inputs are synchronous to clk and that software clears
  flags by writing ones before returning from service.
*/
// Functional notes
// - There are 26 vectors; each but 0 (reset) and the unused 4 and 5 is owned by one peripheral instance fed by one or more sources.
// - A source event sets that source's flag bit in the flags register.
// - Each source has an enable bit in the control register that software writes.
// - A source requests exactly while its enable bit and its flag bit are both set.
// - A request stays up while its flag and enable are both set and falls once either is cleared.
// - Nothing but the non-maskable vector 1 reaches the CPU unless the global interrupt enable is set.
// - Vector 0 is reset and vector 1 is the checksum scan non-maskable interrupt.
// - Vector 2 is the voltage level monitor and vector 3 the port pin change.
// - Vector 6 is the counter count and vector 7 the periodic timer.
// - Timer A uses 8 for overflow or low underflow, 9 for high underflow, 10 to 12 for compares.
// - Vector 13 is timer B, 14 timer D overflow and 15 timer D trigger.
// - Vector 16 is the comparator, 17 converter result ready and 18 converter window.
// - Vector 19 is two-wire target, 20 two-wire controller and 21 SPI.
// - Vectors 22, 23 and 24 are serial receive complete, data empty and transmit complete.
// - Vector 25 is the non-volatile memory controller.
`timescale 1ns/1ps
module pivm_vector_map #(
  parameter int NUM_VEC = 26
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pivm_pkg::pivm_event_type source_event,
  input wire pivm_pkg::pivm_event_type flag_clear_write,
  input wire pivm_pkg::pivm_event_type enable_write_strobe,
  input wire pivm_pkg::pivm_event_type enable_write_data,
  input wire logic global_irq_enable,
  output pivm_pkg::pivm_event_type irq_flags_reg,
  output pivm_pkg::pivm_event_type irq_control_reg,
  output pivm_pkg::pivm_event_type source_request,
  output logic [NUM_VEC-1:0] vector_request,
  output pivm_pkg::pivm_cpu_req_type cpu_request_reg
);
  import pivm_pkg::*;

  localparam int NSRC = $bits(pivm_event_type);

  logic [NSRC-1:0] flags_reg;
  logic [NSRC-1:0] flags_next;
  logic [NSRC-1:0] enable_reg;
  logic [NSRC-1:0] enable_next;
  logic [NSRC-1:0] set_v;
  logic [NSRC-1:0] clr_v;
  logic [NSRC-1:0] wstb_v;
  logic [NSRC-1:0] wdat_v;
  logic [NSRC-1:0] req_v;
  pivm_event_type req_s;
  pivm_cpu_req_type cpu_request_next;
  logic [NUM_VEC-1:0] maskable_req;
  logic any_maskable;
  logic [VEC_WIDTH-1:0] maskable_index;

  assign set_v = source_event;
  assign clr_v = flag_clear_write;
  assign wstb_v = enable_write_strobe;
  assign wdat_v = enable_write_data;

  // Flags and enables share one bit-wise update so every source behaves alike.
  generate
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
      always_comb
      begin
        // A new event in the clearing cycle wins, so no event is lost.
        flags_next[i] = set_v[i] | (flags_reg[i] & ~clr_v[i]);
        enable_next[i] = wstb_v[i] ? wdat_v[i] : enable_reg[i];
        req_v[i] = flags_reg[i] & enable_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      flags_reg <= FLAGS_RESET[NSRC-1:0];
      enable_reg <= ENABLE_RESET[NSRC-1:0];
    end
    else
    begin
      flags_reg <= flags_next;
      enable_reg <= enable_next;
    end
  end

  assign req_s = req_v;
  assign irq_flags_reg = flags_reg;
  assign irq_control_reg = enable_reg;
  assign source_request = req_s;

  // Timer A overflow and low underflow merge onto vector 8; every other source has a vector of its own.
  always_comb
  begin
    vector_request = '0;
    vector_request[VEC_NMI] = req_s.checksum_scan_nmi;
    vector_request[VEC_VLM] = req_s.voltage_level_monitor_irq;
    vector_request[VEC_PORT] = req_s.port_pin_change_irq;
    vector_request[VEC_RTC_COUNT_IRQ] = req_s.rtc_count_irq;
    vector_request[VEC_PERIODIC_TIMER_IRQ] = req_s.periodic_timer_irq;
    vector_request[VEC_TA_OVF] = req_s.timer_a_overflow_irq
                               | req_s.timer_a_low_underflow_irq;
    vector_request[VEC_TA_HUNF] = req_s.timer_a_high_underflow_irq;
    vector_request[VEC_TA_CMP0] = req_s.timer_a_compare0_irq;
    vector_request[VEC_TA_CMP1] = req_s.timer_a_compare1_irq;
    vector_request[VEC_TA_CMP2] = req_s.timer_a_compare2_irq;
    vector_request[VEC_TB] = req_s.timer_b_irq;
    vector_request[VEC_TD_OVF] = req_s.timer_d_overflow_irq;
    vector_request[VEC_TD_TRIG] = req_s.timer_d_trigger_irq;
    vector_request[VEC_AC] = req_s.comparator_irq;
    vector_request[VEC_ADC_RES] = req_s.converter_result_ready_irq;
    vector_request[VEC_ADC_WIN] = req_s.converter_window_irq;
    vector_request[VEC_TWI_T] = req_s.two_wire_target_irq;
    vector_request[VEC_TWI_C] = req_s.two_wire_controller_irq;
    vector_request[VEC_SPI] = req_s.spi_irq;
    vector_request[VEC_RXC] = req_s.serial_rx_complete_irq;
    vector_request[VEC_DRE] = req_s.serial_data_empty_irq;
    vector_request[VEC_TXC] = req_s.serial_tx_complete_irq;
    vector_request[VEC_NVM] = req_s.nvm_ready_irq;
  end

  // Vector 0 is reset, never an interrupt request, so it stays low here.
  always_comb
  begin
    maskable_req = vector_request;
    maskable_req[VEC_RESET] = 1'b0;
    maskable_req[VEC_NMI] = 1'b0;
  end

  pivm_prio_enc #(
    .WIDTH(NUM_VEC),
    .IDX_W(VEC_WIDTH)
  ) u_prio (
    .req(maskable_req),
    .any(any_maskable),
    .index(maskable_index)
  );

  always_comb
  begin
    cpu_request_next.valid = 1'b0;
    cpu_request_next.nmi = 1'b0;
    cpu_request_next.vector = VEC_RESET;
    if (vector_request[VEC_NMI])
    begin
      // The non-maskable vector is the lowest after reset and ignores the global enable.
      cpu_request_next.valid = 1'b1;
      cpu_request_next.nmi = 1'b1;
      cpu_request_next.vector = VEC_NMI;
    end
    else if (global_irq_enable && any_maskable)
    begin
      cpu_request_next.valid = 1'b1;
      cpu_request_next.vector = maskable_index;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cpu_request_reg <= '0;
    end
    else
    begin
      cpu_request_reg <= cpu_request_next;
    end
  end
endmodule : pivm_vector_map

/* pivm_vector_map_props.sv */
/*
  Checker for the vector map, bound to its top module.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pivm_vector_map_props #(
  parameter int NUM_VEC = 26
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pivm_pkg::pivm_event_type flag_clear_write,
  input wire pivm_pkg::pivm_event_type enable_write_strobe,
  input wire pivm_pkg::pivm_event_type enable_write_data,
  input wire logic global_irq_enable,
  input wire pivm_pkg::pivm_event_type irq_flags_reg,
  input wire pivm_pkg::pivm_event_type irq_control_reg,
  input wire pivm_pkg::pivm_event_type source_request,
  input wire logic [NUM_VEC-1:0] vector_request,
  input wire pivm_pkg::pivm_cpu_req_type cpu_request_reg
);
  import pivm_pkg::*;
  logic [NUM_VEC-1:0] vr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) vr_q <= vector_request;
  property p_req; source_request == (irq_flags_reg & irq_control_reg); endproperty
  a_req: assert property (p_req) else $error("request");
  property p_hold; 1 |=> ($past(irq_flags_reg) & ~$past(flag_clear_write) & ~irq_flags_reg) == 0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_en; |enable_write_strobe |=>
    ((irq_control_reg ^ $past(enable_write_data)) & $past(enable_write_strobe)) == 0; endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_gie; !global_irq_enable && !source_request[23] |=> !cpu_request_reg.valid; endproperty
  a_gie: assert property (p_gie) else $error("gated");
  property p_nmi; source_request[23] |=> cpu_request_reg.nmi && cpu_request_reg.vector == VEC_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_low; global_irq_enable && |vector_request |=> vr_q[cpu_request_reg.vector] &&
    (vr_q >> cpu_request_reg.vector) << cpu_request_reg.vector == vr_q; endproperty
  a_low: assert property (p_low) else $error("lowest");
  property p_v8; vector_request[8] == (source_request[18] | source_request[17]); endproperty
  a_v8: assert property (p_v8) else $error("vec8");
  property p_hi; vector_request[25:9] == 17'({<<{source_request[16:0]}}); endproperty
  a_hi: assert property (p_hi) else $error("upper map");
  property p_lo; vector_request[7:0] == {source_request[19], source_request[20], 2'h0,
    source_request[21], source_request[22], source_request[23], 1'h0}; endproperty
  a_lo: assert property (p_lo) else $error("lower map");
endmodule : pivm_vector_map_props
bind pivm_vector_map pivm_vector_map_props #(
  .NUM_VEC(NUM_VEC)
) u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .flag_clear_write(flag_clear_write),
  .enable_write_strobe(enable_write_strobe),
  .enable_write_data(enable_write_data),
  .global_irq_enable(global_irq_enable),
  .irq_flags_reg(irq_flags_reg),
  .irq_control_reg(irq_control_reg),
  .source_request(source_request),
  .vector_request(vector_request),
  .cpu_request_reg(cpu_request_reg)
);

/* testbench.sv */
/*
  Self-checking bench for the vector map with a CPU-side model.
  Assumes the package constants and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import pivm_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, gie = 1'b0, pv = 1'b0;
  pivm_event_type ev = '0, ew = '0, ed = '0, clr, flags, ctl, sreq;
  logic [25:0] vreq;
  pivm_cpu_req_type cpu;
  logic [3:0] lat = 4'h0;
  logic [4:0] expq[$], va, vc, vexp, pvec = 5'h00;
  int n_mismatch = 0, n_compared = 0, seed = 32'hee5f, a, c;
  always #5 clk = ~clk;
  pivm_vector_map dut (.clk(clk), .reset_n(reset_n), .source_event(ev), .flag_clear_write(clr),
    .enable_write_strobe(ew), .enable_write_data(ed), .global_irq_enable(gie),
    .irq_flags_reg(flags), .irq_control_reg(ctl), .source_request(sreq),
    .vector_request(vreq), .cpu_request_reg(cpu));
  pivm_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .cpu_request(cpu), .lat(lat), .clr(clr));
  task chk_vec(string w, logic [4:0] e, logic [4:0] g);
    n_compared++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask : chk_vec
  task chk_bit(string w, logic e, logic g);
    chk_vec(w, {4'h0, e}, {4'h0, g});
  endtask : chk_bit
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task fire(int b);
    ev[b] = 1'b1;
    step(1);
    ev = '0;
  endtask : fire
  task drain;
    int k;
    for (k = 0; k < 60 && (cpu.valid || expq.size() > 0); k++)
      step(1);
    if (k == 60)
    begin
      n_mismatch++;
      test_done;
    end
  endtask : drain
  // Each new winner on the request register consumes the oldest expectation.
  always @(posedge clk)
  begin
    #2;
    if (cpu.valid && (!pv || cpu.vector !== pvec))
    begin
      vexp = expq.size() ? expq.pop_front() : 5'h1f;
      chk_vec("vector", vexp, cpu.vector);
      chk_bit("nmi", vexp == VEC_NMI, cpu.nmi);
    end
    pv = cpu.valid;
    pvec = cpu.vector;
  end
  initial
  begin
    step(12);
    reset_n = 1'b1;
    ew = '1;
    ed = '1;
    step(1);
    ew = '0;
    gie = 1'b1;
    for (int b = 0; b < 24; b++)
    begin
      lat = 4'($random(seed));
      expq.push_back(u_cpu.vec_of(b));
      fire(b);
      drain;
    end
    $display("test single sources done");
    repeat (20)
    begin
      a = {$random(seed)} % 24;
      c = {$random(seed)} % 24;
      va = u_cpu.vec_of(a);
      vc = u_cpu.vec_of(c);
      expq.push_back(va < vc ? va : vc);
      if (va != vc)
        expq.push_back(va < vc ? vc : va);
      ev[a] = 1;
      ev[c] = 1;
      step(1);
      ev = '0;
      drain;
    end
    $display("test pairs done");
    gie = 1'b0;
    fire(5);
    step(10);
    chk_bit("blocked", 1'h0, cpu.valid);
    chk_bit("line", 1'h1, vreq[20]);
    expq.push_back(5'h01);
    fire(23);
    drain;
    expq.push_back(5'h14);
    gie = 1'b1;
    drain;
    $display("test global enable done");
    ew = '1;
    ed = '0;
    step(1);
    ew = '0;
    fire(0);
    step(2);
    chk_bit("flag", 1'h1, flags[0]);
    chk_bit("request", 1'h0, sreq[0]);
    expq.push_back(5'h19);
    ew[0] = 1'b1;
    ed[0] = 1'b1;
    step(1);
    ew = '0;
    chk_bit("control", 1'h1, ctl[0]);
    chk_bit("control", 1'h0, ctl[1]);
    drain;
    $display("test enable done");
    test_done;
  end
endmodule : testbench
